//--- pkg/cfs_pkg.sv
/*
  constants, register map and carriers for the clock and fault supervisor.
  assumes one system clock at 20 MHz and an APB register port with 32-bit data.
*/
package cfs_pkg;

  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned CLK_NS = 50;

  // register byte offsets
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] GATE_OFS = 8'h04;
  localparam logic [7:0] OCTH_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;

  // clock source codes
  localparam logic [1:0] SRC_INT = 2'h0;
  localparam logic [1:0] SRC_XTAL = 2'h1;
  localparam logic [1:0] SRC_DIRECT = 2'h2;

  // thermal states
  localparam logic [1:0] TH_NORMAL = 2'h0;
  localparam logic [1:0] TH_WARN = 2'h1;
  localparam logic [1:0] TH_BRIDGE_SD = 2'h2;
  localparam logic [1:0] TH_DEVICE_SD = 2'h3;

  // timing
  localparam int unsigned EXT_STARTUP_US = 4000;
  localparam int unsigned BLANK_STEP_NS = 125;
  localparam int unsigned OC_STEP_UV = 31250;
  localparam int unsigned WD_TIMEOUT_CYCLES = 16;

  // field positions
  localparam int unsigned CFG_SRC_LSB = 0;
  localparam int unsigned CFG_FSEL_LSB = 2;
  localparam int unsigned CFG_CLKOUT_BIT = 4;
  localparam int unsigned CFG_OCSD_BIT = 5;
  localparam int unsigned CFG_UVSET_BIT = 6;
  localparam int unsigned GATE_WD_BIT = 0;
  localparam int unsigned GATE_BLANK_LSB = 1;

  typedef struct packed {
    logic undervoltage_set_select;
    logic overcurrent_shutdown_enable;
    logic clock_output_enable;
    logic [1:0] oscillator_frequency_select;
    logic [1:0] external_clock_select;
  } cfs_cfg_t;

  typedef struct packed {
    logic [2:0] blanking_code;
    logic clock_watchdog_enable;
  } cfs_gate_t;

  typedef struct packed {
    logic clock_failed;
    logic clock_on_external;
    logic bridges_latched_off;
    logic [1:0] thermal_state_field;
    logic adc_input_undervoltage_flag;
    logic gate_supply_undervoltage_flag;
    logic overcurrent_flag;
  } cfs_status_t;

  // reset values: internal oscillator, 2 MHz on the clock output, shutdown on overcurrent
  localparam cfs_cfg_t CFG_RST = '{1'b0, 1'b1, 1'b1, 2'h0, SRC_INT};
  localparam cfs_gate_t GATE_RST = '{3'h0, 1'b0};
  localparam logic [4:0] OCTH_RST = 5'h08;

endpackage

//--- design/cfs_supervisor.sv
/*
  clock source selection, clock output pin, external clock watchdog and
  sticky fault flags gating the power bridges, with an APB register port.
  assumes comparator and pin inputs are synchronous to pclk; the clock mux
  and oscillator themselves are analog cells steered by the outputs here.
*/
// How it works
// - logic clock from internal, resonator or direct
// - reset starts internal oscillator, 2 MHz out
// - internal mode ignores input, output picks frequency
// - external sources offer 8/16/24/32 MHz
// - direct clock: output pin is inverted input
// - enabled watchdog resets on external clock loss
// - stay internal for startup time, then switch
// - overcurrent flag low until gone and read
// - 32 threshold codes, (n+1) x 31.25 mV
// - comparator masked: hiz, commutating, blanking, gate off
// - bit chooses shutdown or flag only
// - bridges stay off until flag released
// - supply low: transistors off at once, flag low next cycle
// - off until supplies ok, then read clears
// - one bit selects lower or higher thresholds
// - adc undervoltage flag low until gone and read
// - adc undervoltage never turns bridges off
// - thermal field encodes four states
// - warning state only reports
// - bridge shutdown: gates off, clamps kept
// - device shutdown: regulators, pump off, clamps kept
// - reset pin low holds bridges, gates, vcc and pump off, defaults
module cfs_supervisor #(
  parameter int unsigned STARTUP_CYCLES = cfs_pkg::EXT_STARTUP_US * cfs_pkg::CLK_MHZ,
  parameter int unsigned HALF_BRIDGES = 4
) (
  // clock and standby/reset pin
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock pins and oscillator control
  input wire logic clock_input_pin,
  input wire logic osc_divided_clock,
  output logic clock_output_pin_o,
  output logic clock_output_pin_oe,
  output logic internal_osc_enable,
  output logic resonator_driver_enable,
  output logic logic_clock_from_pin,
  output logic [1:0] clock_frequency_code,
  output logic clock_fail_reset,
  // half-bridge state and comparators
  input wire logic [HALF_BRIDGES-1:0] oc_compare,
  input wire logic [HALF_BRIDGES-1:0] bridge_hiz,
  input wire logic [HALF_BRIDGES-1:0] bridge_commutating,
  input wire logic [HALF_BRIDGES-1:0] gate_off,
  input wire logic bridge_on_request,
  output logic [19:0] oc_threshold_uv,
  // supply and thermal comparators
  input wire logic gate_supply_below_off,
  input wire logic gate_supply_above_on,
  input wire logic adc_below_limit,
  input wire logic thermal_warn_level,
  input wire logic thermal_bridge_level,
  input wire logic thermal_device_level,
  output logic undervoltage_set_select,
  // power stage control
  output logic bridges_enable,
  output logic gate_drivers_enable,
  output logic miller_clamp_enable,
  output logic vcc_regulator_enable,
  output logic charge_pump_enable,
  output logic vreg_current_limit
);

  localparam int unsigned STW = $clog2(STARTUP_CYCLES + 1);

  function automatic logic [4:0] blank_cycles(input logic [2:0] code);
    int unsigned ns;
    ns = (int'(code) + 1) * cfs_pkg::BLANK_STEP_NS;
    return 5'((ns + cfs_pkg::CLK_NS - 1) / cfs_pkg::CLK_NS);
  endfunction

  function automatic logic [19:0] oc_uv(input logic [4:0] code);
    return 20'((int'(code) + 1) * cfs_pkg::OC_STEP_UV);
  endfunction

  cfs_pkg::cfs_cfg_t cfg_r;
  cfs_pkg::cfs_gate_t gate_r;
  logic [4:0] octh_r;
  cfs_pkg::cfs_status_t stat;
  logic wr_acc, rd_setup, status_read, mapped;
  logic [STW-1:0] startup_r;
  logic ext_active_r;
  logic pin_prev_r;
  logic [4:0] wd_cnt_r;
  logic wd_fail;
  logic [HALF_BRIDGES-1:0] oc_masked;
  logic [4:0] blank_r [HALF_BRIDGES];
  logic oc_event, oc_flag_n_r, oc_off_r;
  logic uv_event_r, uv_flag_n_r;
  logic adc_flag_n_r;
  logic [1:0] th_state;
  logic bridge_r;
  logic clk_failed_r;

  // apb decode; one wait-free access, read data captured in the setup cycle
  assign mapped = paddr inside {cfs_pkg::CFG_OFS, cfs_pkg::GATE_OFS, cfs_pkg::OCTH_OFS, cfs_pkg::STAT_OFS};
  assign wr_acc = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  // reading status is the read-and-clear-flags command
  assign status_read = psel && penable && !pwrite && paddr == cfs_pkg::STAT_OFS;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (paddr)
        cfs_pkg::CFG_OFS: prdata <= 32'(cfg_r);
        cfs_pkg::GATE_OFS: prdata <= 32'(gate_r);
        cfs_pkg::OCTH_OFS: prdata <= 32'(octh_r);
        cfs_pkg::STAT_OFS: prdata <= 32'(stat);
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // configuration; the host owns source changes only across a reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= cfs_pkg::CFG_RST;
      gate_r <= cfs_pkg::GATE_RST;
      octh_r <= cfs_pkg::OCTH_RST;
    end else if (wd_fail) begin
      cfg_r <= cfs_pkg::CFG_RST;
      gate_r <= cfs_pkg::GATE_RST;
      octh_r <= cfs_pkg::OCTH_RST;
    end else if (wr_acc) begin
      case (paddr)
        cfs_pkg::CFG_OFS: cfg_r <= cfs_pkg::cfs_cfg_t'(pwdata[6:0]);
        cfs_pkg::GATE_OFS: gate_r <= cfs_pkg::cfs_gate_t'(pwdata[3:0]);
        cfs_pkg::OCTH_OFS: octh_r <= pwdata[4:0];
        default: ;
      endcase
    end
  end

  assign oc_threshold_uv = oc_uv(octh_r);
  assign undervoltage_set_select = cfg_r.undervoltage_set_select;
  assign clock_frequency_code = cfg_r.oscillator_frequency_select;

  // startup delay before the logic clock moves to the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      startup_r <= '0;
      ext_active_r <= 1'b0;
    end else if (wd_fail || cfg_r.external_clock_select == cfs_pkg::SRC_INT) begin
      startup_r <= '0;
      ext_active_r <= 1'b0;
    end else if (!ext_active_r) begin
      if (startup_r == STW'(STARTUP_CYCLES - 1)) begin
        ext_active_r <= 1'b1;
      end else begin
        startup_r <= startup_r + 1'b1;
      end
    end
  end

  assign internal_osc_enable = !ext_active_r;
  assign logic_clock_from_pin = ext_active_r;
  assign resonator_driver_enable = cfg_r.external_clock_select == cfs_pkg::SRC_XTAL;

  // clock output pin is a clock path, so it is muxed, not registered
  always_comb begin
    clock_output_pin_o = 1'b0;
    clock_output_pin_oe = 1'b0;
    case (cfg_r.external_clock_select)
      cfs_pkg::SRC_INT: begin
        clock_output_pin_o = osc_divided_clock;
        clock_output_pin_oe = cfg_r.clock_output_enable;
      end
      cfs_pkg::SRC_DIRECT: begin
        clock_output_pin_o = !clock_input_pin;
        clock_output_pin_oe = 1'b1;
      end
      default: ;
    endcase
  end

  // watchdog: counts pclk cycles without a pin transition; an external clock
  // slower than pclk/2 works, a faster one may alias, so timeout is generous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_r <= 1'b0;
      wd_cnt_r <= '0;
    end else begin
      pin_prev_r <= clock_input_pin;
      if (!ext_active_r || !gate_r.clock_watchdog_enable || pin_prev_r != clock_input_pin || wd_fail) begin
        wd_cnt_r <= '0;
      end else begin
        wd_cnt_r <= wd_cnt_r + 1'b1;
      end
    end
  end

  assign wd_fail = wd_cnt_r == 5'(cfs_pkg::WD_TIMEOUT_CYCLES);
  assign clock_fail_reset = wd_fail;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_failed_r <= 1'b0;
    end else if (wd_fail) begin
      clk_failed_r <= 1'b1;
    end else if (status_read) begin
      clk_failed_r <= 1'b0;
    end
  end

  // blanking after each commutation, per half-bridge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < HALF_BRIDGES; i++) begin
        blank_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < HALF_BRIDGES; i++) begin
        if (bridge_commutating[i]) begin
          blank_r[i] <= blank_cycles(gate_r.blanking_code);
        end else if (blank_r[i] != '0) begin
          blank_r[i] <= blank_r[i] - 1'b1;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < HALF_BRIDGES; i++) begin
      oc_masked[i] = oc_compare[i] && !bridge_hiz[i] && !bridge_commutating[i]
                     && blank_r[i] == '0 && !gate_off[i];
    end
  end

  assign oc_event = |oc_masked;

  // sticky flags: a new event in the read cycle keeps the flag low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_flag_n_r <= 1'b1;
      oc_off_r <= 1'b0;
    end else if (wd_fail) begin
      oc_flag_n_r <= 1'b1;
      oc_off_r <= 1'b0;
    end else if (oc_event) begin
      oc_flag_n_r <= 1'b0;
      if (cfg_r.overcurrent_shutdown_enable) begin
        oc_off_r <= 1'b1;
      end
    end else if (status_read) begin
      oc_flag_n_r <= 1'b1;
      oc_off_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_event_r <= 1'b0;
      uv_flag_n_r <= 1'b1;
    end else begin
      if (gate_supply_below_off) begin
        uv_event_r <= 1'b1;
      end else if (gate_supply_above_on) begin
        uv_event_r <= 1'b0;
      end
      if (gate_supply_below_off) begin
        uv_flag_n_r <= 1'b0;
      end else if (status_read && !uv_event_r) begin
        uv_flag_n_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_flag_n_r <= 1'b1;
    end else if (adc_below_limit) begin
      adc_flag_n_r <= 1'b0;
    end else if (status_read) begin
      adc_flag_n_r <= 1'b1;
    end
  end

  // thermal levels carry their own hysteresis in the sensor
  always_comb begin
    if (thermal_device_level) begin
      th_state = cfs_pkg::TH_DEVICE_SD;
    end else if (thermal_bridge_level) begin
      th_state = cfs_pkg::TH_BRIDGE_SD;
    end else if (thermal_warn_level) begin
      th_state = cfs_pkg::TH_WARN;
    end else begin
      th_state = cfs_pkg::TH_NORMAL;
    end
  end

  // adc undervoltage deliberately absent from the bridge gate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bridge_r <= 1'b0;
    end else begin
      bridge_r <= bridge_on_request && !oc_off_r && !(oc_event && cfg_r.overcurrent_shutdown_enable)
                  && !uv_event_r && !gate_supply_below_off && th_state < cfs_pkg::TH_BRIDGE_SD
                  && !wd_fail;
    end
  end

  // the supply comparator cuts the bridges in the same cycle
  assign bridges_enable = bridge_r && !gate_supply_below_off;
  assign gate_drivers_enable = presetn && th_state < cfs_pkg::TH_BRIDGE_SD;
  assign miller_clamp_enable = th_state >= cfs_pkg::TH_BRIDGE_SD;
  assign vcc_regulator_enable = presetn && th_state != cfs_pkg::TH_DEVICE_SD;
  assign charge_pump_enable = presetn && th_state != cfs_pkg::TH_DEVICE_SD;
  assign vreg_current_limit = !presetn || th_state == cfs_pkg::TH_DEVICE_SD;

  always_comb begin
    stat.clock_failed = clk_failed_r;
    stat.clock_on_external = ext_active_r;
    stat.bridges_latched_off = oc_off_r;
    stat.thermal_state_field = th_state;
    stat.adc_input_undervoltage_flag = adc_flag_n_r;
    stat.gate_supply_undervoltage_flag = uv_flag_n_r;
    stat.overcurrent_flag = oc_flag_n_r;
  end

  // checks
  property p_oc_sticky;
    @(posedge pclk) disable iff (!presetn)
    oc_event && !wd_fail |=> !oc_flag_n_r;
  endproperty
  a_oc_sticky: assert property (p_oc_sticky) else $error("overcurrent flag not set");

  property p_oc_hold;
    @(posedge pclk) disable iff (!presetn)
    !oc_flag_n_r && !status_read && !wd_fail |=> !oc_flag_n_r;
  endproperty
  a_oc_hold: assert property (p_oc_hold) else $error("overcurrent flag released without read");

  property p_oc_latch;
    @(posedge pclk) disable iff (!presetn)
    oc_off_r |=> !bridge_r;
  endproperty
  a_oc_latch: assert property (p_oc_latch) else $error("bridges on while overcurrent latched");

  property p_oc_flag_only;
    @(posedge pclk) disable iff (!presetn)
    oc_event && !cfg_r.overcurrent_shutdown_enable && !oc_off_r |=> !oc_off_r;
  endproperty
  a_oc_flag_only: assert property (p_oc_flag_only) else $error("shutdown despite flag-only mode");

  property p_uv_off;
    @(posedge pclk) disable iff (!presetn)
    gate_supply_below_off |-> !bridges_enable ##1 (!uv_flag_n_r && !bridge_r);
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("undervoltage did not cut bridges");

  property p_uv_hold;
    @(posedge pclk) disable iff (!presetn)
    uv_event_r && !gate_supply_above_on |=> uv_event_r && !uv_flag_n_r ##0 !bridges_enable;
  endproperty
  a_uv_hold: assert property (p_uv_hold) else $error("undervoltage released early");

  property p_adc_no_off;
    @(posedge pclk) disable iff (!presetn)
    adc_below_limit && bridge_on_request && !oc_off_r && !oc_event && !uv_event_r && !gate_supply_below_off
    && th_state < cfs_pkg::TH_BRIDGE_SD && !wd_fail |=> bridge_r;
  endproperty
  a_adc_no_off: assert property (p_adc_no_off) else $error("adc undervoltage cut bridges");

  property p_th_bridge;
    @(posedge pclk) disable iff (!presetn)
    thermal_bridge_level |-> !gate_drivers_enable && miller_clamp_enable ##1 !bridge_r;
  endproperty
  a_th_bridge: assert property (p_th_bridge) else $error("bridge shutdown not applied");

  property p_th_device;
    @(posedge pclk) disable iff (!presetn)
    thermal_device_level |-> th_state == 2'h3 && !charge_pump_enable && !vcc_regulator_enable && vreg_current_limit;
  endproperty
  a_th_device: assert property (p_th_device) else $error("device shutdown not applied");

  property p_startup;
    @(posedge pclk) disable iff (!presetn)
    $rose(ext_active_r) |-> $past(startup_r) == STW'(STARTUP_CYCLES - 1);
  endproperty
  a_startup: assert property (p_startup) else $error("switched before startup time");

  property p_direct_out;
    @(posedge pclk) disable iff (!presetn)
    cfg_r.external_clock_select == cfs_pkg::SRC_DIRECT |-> clock_output_pin_oe && clock_output_pin_o == !clock_input_pin;
  endproperty
  a_direct_out: assert property (p_direct_out) else $error("direct clock not inverted on output");

  property p_wd;
    @(posedge pclk) disable iff (!presetn)
    wd_fail |=> cfg_r == cfs_pkg::CFG_RST && !ext_active_r && !gate_r.clock_watchdog_enable;
  endproperty
  a_wd: assert property (p_wd) else $error("clock loss did not reset");

endmodule

//--- tb/cfs_clock_source.sv
/*
  stand-in for the oscillator divider and the external clock pin.
  assumes pclk clocks it; the external clock freezes while ext_run is low.
*/
module cfs_clock_source (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control from the bench
  input wire logic ext_run,
  input wire logic [1:0] freq_code,
  // pins
  output logic clock_input_pin,
  output logic osc_divided_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] div_r;
  logic [1:0] ext_r = 2'h0;
  // code 0 is the slowest output, so it takes the highest tap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end
  assign osc_divided_clock = div_r[2'd3 - freq_code];
  // runs through reset since the source sits outside the device;
  // a stopped source stands still, which is what the watchdog must catch
  always_ff @(posedge pclk) begin
    if (ext_run) begin
      ext_r <= ext_r + 2'h1;
    end
  end
  assign clock_input_pin = ext_r[1];
endmodule

//--- tb/cfs_supervisor_bench.sv
/*
  bench for the clock and fault supervisor: apb tasks and one task per scenario.
  assumes cfs_clock_source stands in for the oscillator and the clock pin.
*/
module cfs_supervisor_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned SC = 20;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, ck_in, osc_div, ck_o, ck_oe, osc_en, res_en, from_pin, fail_rst;
  logic [1:0] fcode;
  logic [3:0] oc = 4'h0, hiz = 4'h0, comm = 4'h0, goff = 4'h0;
  logic req = 0, uv_off = 0, uv_on = 1, adc_lo = 0, t_w = 0, t_b = 0, t_d = 0, ext_run = 1;
  logic [19:0] th_uv;
  logic uv_sel, br_en, gd_en, mc_en, vcc_en, cp_en, vreg_lim;
  int error_cnt = 0;
  int checks = 0;
  always #25 pclk = ~pclk;

  cfs_supervisor #(.STARTUP_CYCLES(SC), .HALF_BRIDGES(4)) cfs_supervisor_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_input_pin(ck_in), .osc_divided_clock(osc_div), .clock_output_pin_o(ck_o),
    .clock_output_pin_oe(ck_oe), .internal_osc_enable(osc_en), .resonator_driver_enable(res_en),
    .logic_clock_from_pin(from_pin), .clock_frequency_code(fcode), .clock_fail_reset(fail_rst),
    .oc_compare(oc), .bridge_hiz(hiz), .bridge_commutating(comm), .gate_off(goff),
    .bridge_on_request(req), .oc_threshold_uv(th_uv), .gate_supply_below_off(uv_off),
    .gate_supply_above_on(uv_on), .adc_below_limit(adc_lo), .thermal_warn_level(t_w),
    .thermal_bridge_level(t_b), .thermal_device_level(t_d), .undervoltage_set_select(uv_sel),
    .bridges_enable(br_en), .gate_drivers_enable(gd_en), .miller_clamp_enable(mc_en),
    .vcc_regulator_enable(vcc_en), .charge_pump_enable(cp_en), .vreg_current_limit(vreg_lim));

  cfs_clock_source cfs_clock_source_inst (.pclk(pclk), .presetn(presetn), .ext_run(ext_run),
    .freq_code(fcode), .clock_input_pin(ck_in), .osc_divided_clock(osc_div));

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // hold the request until pready is seen high at a rising edge
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      finish_test();
    end else begin
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1, a, d, q, e);
  endtask

  task automatic rdc(logic [7:0] a, logic [31:0] exp, string nm);
    logic [31:0] q;
    logic e;
    apb(0, a, 32'h0000_0000, q, e);
    chk(nm, exp, q);
  endtask

  // status reads double as the read-and-clear command
  task automatic stat_bit(int b, logic exp, string nm);
    logic [31:0] q;
    logic e;
    apb(0, cfs_pkg::STAT_OFS, 32'h0000_0000, q, e);
    chk(nm, exp, q[b]);
  endtask

  task automatic do_reset();
    @(posedge pclk) presetn <= 0;
    repeat (8) @(posedge pclk);
    presetn <= 1;
  endtask

  task automatic t_defaults();
    logic [31:0] q;
    logic e;
    rdc(cfs_pkg::CFG_OFS, 32'h0000_0030, "cfg_reset");
    rdc(cfs_pkg::GATE_OFS, 32'h0000_0000, "gate_reset");
    rdc(cfs_pkg::OCTH_OFS, 32'h0000_0008, "octh_reset");
    cyc(1);
    chk("osc_enable", 1, osc_en);
    chk("clkout_oe", 1, ck_oe);
    chk("clkout_code", 0, fcode);
    apb(0, 8'h10, 32'h0000_0000, q, e);
    chk("unmapped_err", 1, e);
    chk("unmapped_data", 0, q);
  endtask

  task automatic t_clkout();
    for (int f = 0; f < 4; f++) begin
      do_reset();
      wr(cfs_pkg::CFG_OFS, 32'h0000_0030 | (f << 2));
      cyc(1);
      chk("int_code", f, fcode);
      repeat (6) begin
        chk("int_out", osc_div, ck_o);
        cyc(1);
      end
    end
    do_reset();
    wr(cfs_pkg::CFG_OFS, 32'h0000_0020);
    cyc(1);
    chk("int_out_off", 0, ck_oe);
  endtask

  task automatic t_thresh();
    int codes[4] = '{0, 1, 15, 31};
    foreach (codes[i]) begin
      wr(cfs_pkg::OCTH_OFS, 32'hFFFF_FFE0 | codes[i]);
      cyc(1);
      chk("oc_thresh", (codes[i] + 1) * 31250, th_uv);
      rdc(cfs_pkg::OCTH_OFS, codes[i], "octh_read");
    end
  endtask

  task automatic t_oc();
    wr(cfs_pkg::CFG_OFS, 32'h0000_0030);
    @(posedge pclk) req <= 1;
    cyc(3);
    chk("bridges_on", 1, br_en);
    @(posedge pclk) oc <= 4'h2;
    cyc(3);
    chk("oc_shutdown", 0, br_en);
    stat_bit(0, 0, "oc_flag_set");
    stat_bit(5, 1, "oc_latched");
    @(posedge pclk) oc <= 4'h0;
    cyc(3);
    chk("oc_still_off", 0, br_en);
    stat_bit(0, 0, "oc_flag_held");
    stat_bit(0, 1, "oc_flag_clear");
    cyc(3);
    chk("oc_reenabled", 1, br_en);
    for (int k = 0; k < 2; k++) begin
      @(posedge pclk) {hiz, goff, oc} <= k ? 12'h022 : 12'h202;
      cyc(3);
      chk("oc_masked_br", 1, br_en);
      stat_bit(0, 1, "oc_masked_flag");
    end
    // longest blanking, 1000 ns = 20 cycles after commutation ends;
    // the first read samples near the end of that window
    wr(cfs_pkg::GATE_OFS, 32'h0000_000E);
    @(posedge pclk) {hiz, goff, comm, oc} <= 16'h0011;
    cyc(3);
    @(posedge pclk) comm <= 4'h0;
    cyc(16);
    stat_bit(0, 1, "oc_blanked");
    cyc(25);
    stat_bit(0, 0, "oc_after_blank");
    // flag only: release the latch first, then bridges stay on
    @(posedge pclk) oc <= 4'h0;
    stat_bit(0, 0, "oc_blank_held");
    wr(cfs_pkg::CFG_OFS, 32'h0000_0010);
    @(posedge pclk) oc <= 4'h1;
    cyc(3);
    stat_bit(0, 0, "oc_flag_only_set");
    chk("oc_no_shutdown", 1, br_en);
    @(posedge pclk) oc <= 4'h0;
    stat_bit(0, 0, "oc_preclear");
    stat_bit(0, 1, "oc_cleared");
  endtask

  task automatic t_uv();
    @(posedge pclk) {uv_off, uv_on} <= 2'b10;
    #1;
    chk("uv_immediate_off", 0, br_en);
    stat_bit(1, 0, "uv_flag_set");
    @(posedge pclk) uv_off <= 0;
    stat_bit(1, 0, "uv_flag_held");
    chk("uv_still_off", 0, br_en);
    @(posedge pclk) uv_on <= 1;
    stat_bit(1, 0, "uv_preclear");
    stat_bit(1, 1, "uv_cleared");
    cyc(3);
    chk("uv_reenabled", 1, br_en);
    wr(cfs_pkg::CFG_OFS, 32'h0000_0070);
    cyc(1);
    chk("uv_set_high", 1, uv_sel);
    wr(cfs_pkg::CFG_OFS, 32'h0000_0030);
    cyc(1);
    chk("uv_set_low", 0, uv_sel);
  endtask

  task automatic t_adc();
    @(posedge pclk) adc_lo <= 1;
    cyc(3);
    chk("adc_no_shutdown", 1, br_en);
    stat_bit(2, 0, "adc_flag_set");
    @(posedge pclk) adc_lo <= 0;
    stat_bit(2, 0, "adc_preclear");
    stat_bit(2, 1, "adc_cleared");
  endtask

  // {warn, bridge, device} levels against {field, bridges, gates, vcc, pump, limit}
  task automatic t_thermal();
    logic [2:0] lv[5] = '{3'b000, 3'b100, 3'b110, 3'b111, 3'b001};
    logic [6:0] ex[5] = '{7'h1E, 7'h3E, 7'h46, 7'h61, 7'h61};
    logic [31:0] q;
    logic e;
    foreach (lv[i]) begin
      @(posedge pclk) {t_w, t_b, t_d} <= lv[i];
      cyc(3);
      apb(0, cfs_pkg::STAT_OFS, 32'h0000_0000, q, e);
      chk("thermal", ex[i], {q[4:3], br_en, gd_en, vcc_en, cp_en, vreg_lim});
      if (ex[i][6]) begin
        chk("clamps_kept", 1, mc_en);
      end
    end
    @(posedge pclk) {t_w, t_b, t_d} <= 3'b000;
  endtask

  task automatic t_clock();
    int n;
    for (int f = 0; f < 4; f++) begin
      do_reset();
      wr(cfs_pkg::CFG_OFS, 32'h0000_0032 | (f << 2));
      cyc(1);
      chk("ext_code", f, fcode);
      chk("still_internal", 2'b10, {osc_en, from_pin});
      chk("direct_oe", 1, ck_oe);
      chk("direct_inverted", !ck_in, ck_o);
      cyc(SC + 2);
      chk("on_pin", 1, {osc_en, from_pin});
      stat_bit(6, 1, "ext_status");
    end
    n = 0;
    @(posedge pclk) ext_run <= 0;
    repeat (30) begin
      cyc(1);
      n += (fail_rst === 1'b1);
    end
    chk("watchdog_off", 0, n);
    @(posedge pclk) ext_run <= 1;
    wr(cfs_pkg::GATE_OFS, 32'h0000_0001);
    @(posedge pclk) ext_run <= 0;
    n = 0;
    while (n < 40 && fail_rst !== 1'b1) begin
      cyc(1);
      n++;
    end
    chk("watchdog_fired", 1, fail_rst);
    cyc(3);
    rdc(cfs_pkg::CFG_OFS, 32'h0000_0030, "cfg_reloaded");
    stat_bit(7, 1, "clock_fail_seen");
    @(posedge pclk) ext_run <= 1;
    do_reset();
    wr(cfs_pkg::CFG_OFS, 32'h0000_0031);
    cyc(1);
    chk("resonator", 2'b10, {res_en, ck_oe});
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    chk("rst_bridges", 0, {br_en, gd_en});
    chk("rst_vreg_limit", 1, vreg_lim);
    presetn <= 1;
    t_defaults();
    t_clkout();
    t_thresh();
    t_oc();
    t_uv();
    t_adc();
    t_thermal();
    t_clock();
    finish_test();
  end
endmodule
